//--- rtl/trx_top.sv
// Table read and exclusive-or execution unit with AXI4-Lite register slave
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`default_nettype none
module trx_top
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// AXI4-Lite write channels
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [trx_pkg::AXI_AW-1:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [trx_pkg::AXI_DW-1:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// AXI4-Lite read channels
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [trx_pkg::AXI_AW-1:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [trx_pkg::AXI_DW-1:0] o_rdata,
	output logic [1:0] o_rresp,
	// Program memory read port
	output logic o_pm_rd,
	output logic [trx_pkg::PM_AW-1:0] o_pm_addr,
	input wire logic [trx_pkg::WORD_W-1:0] i_pm_data,
	// Data memory port
	output logic o_dm_rd,
	output logic o_dm_wr,
	output logic [trx_pkg::PTR_W-1:0] o_dm_addr,
	output logic [trx_pkg::DATA_W-1:0] o_dm_wdata,
	input wire logic [trx_pkg::DATA_W-1:0] i_dm_rdata,
	// Status
	output logic o_busy
);
	trx_pkg::trx_top_state_type s_r;
	trx_pkg::trx_top_state_type s_nxt;
	logic xor_en;
	logic [trx_pkg::DATA_W-1:0] xor_b;
	logic [trx_pkg::DATA_W-1:0] xor_res;
	logic xor_zero;
	logic busy_r;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction

	trx_xor_unit u_xor
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_en(xor_en),
		.i_a(s_r.acc),
		.i_b(xor_b),
		.o_res(xor_res),
		.o_zero(xor_zero)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic [31:0] cur;
		logic [31:0] wv;
		logic [trx_pkg::AXI_AW-1:0] wa;
		logic [trx_pkg::AXI_AW-1:0] ra;
		logic busy;
		logic start;
		cur = '0;
		wv = '0;
		wa = {i_awaddr[trx_pkg::AXI_AW-1:2], 2'h0};
		ra = {i_araddr[trx_pkg::AXI_AW-1:2], 2'h0};
		busy = (s_r.state != trx_pkg::ST_IDLE);
		start = 1'b0;
		s_nxt = s_r;
		s_nxt.awready = 1'b0;
		s_nxt.wready = 1'b0;
		s_nxt.arready = 1'b0;
		s_nxt.pm_rd = 1'b0;
		s_nxt.dm_rd = 1'b0;
		s_nxt.dm_wr = 1'b0;
		xor_en = 1'b0;
		xor_b = i_dm_rdata;

		// Both address and data are taken in one cycle, one write at a time
		if (!s_r.bvalid && !s_r.awready && i_awvalid && i_wvalid)
		begin
			s_nxt.awready = 1'b1;
			s_nxt.wready = 1'b1;
		end
		if (s_r.bvalid && i_bready)
			s_nxt.bvalid = 1'b0;
		if (s_r.awready && i_awvalid && i_wvalid)
		begin
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = trx_pkg::RESP_OKAY;
			// Writes during an instruction would tear its operands
			if (busy)
				s_nxt.bresp = trx_pkg::RESP_SLVERR;
			else
			begin
				case (wa)
				trx_pkg::REG_CMD:
				begin
					cur = 32'(s_r.op) | (32'(s_r.maddr) << trx_pkg::CMD_MADDR_LSB)
						| (32'(s_r.imm) << trx_pkg::CMD_IMM_LSB);
					wv = merge(cur, i_wdata, i_wstrb);
					s_nxt.op = wv[trx_pkg::CMD_OP_LSB +: 3];
					s_nxt.maddr = wv[trx_pkg::CMD_MADDR_LSB +: trx_pkg::PTR_W];
					s_nxt.imm = wv[trx_pkg::CMD_IMM_LSB +: trx_pkg::DATA_W];
					s_nxt.reject = (s_nxt.op > 3'(trx_pkg::OP_XOR_IMM));
					if (s_nxt.reject)
						s_nxt.bresp = trx_pkg::RESP_SLVERR;
					else
						start = 1'b1;
				end
				trx_pkg::REG_ACC:
				begin
					wv = merge(32'(s_r.acc), i_wdata, i_wstrb);
					s_nxt.acc = wv[trx_pkg::DATA_W-1:0];
				end
				trx_pkg::REG_TABLE_LOW_POINTER:
				begin
					wv = merge(32'(s_r.table_low_pointer), i_wdata, i_wstrb);
					s_nxt.table_low_pointer = wv[trx_pkg::PTR_W-1:0];
				end
				trx_pkg::REG_TABLE_HIGH_POINTER:
				begin
					cur = 32'(s_r.table_high_pointer) | (32'(s_r.table_high_pointer_en) << trx_pkg::TABLE_HIGH_POINTER_EN_BIT);
					wv = merge(cur, i_wdata, i_wstrb);
					s_nxt.table_high_pointer = wv[trx_pkg::PAGE_W-1:0];
					s_nxt.table_high_pointer_en = wv[trx_pkg::TABLE_HIGH_POINTER_EN_BIT];
				end
				trx_pkg::REG_PAGE:
				begin
					wv = merge(32'(s_r.page), i_wdata, i_wstrb);
					s_nxt.page = wv[trx_pkg::PAGE_W-1:0];
				end
				trx_pkg::REG_FLAGS:
				begin
					wv = merge(32'(s_r.flags), i_wdata, i_wstrb);
					s_nxt.flags = wv[trx_pkg::FLAG_W-1:0];
				end
				default:
					s_nxt.bresp = trx_pkg::RESP_SLVERR;
				endcase
			end
		end

		// Read channel
		if (!s_r.rvalid && !s_r.arready && i_arvalid)
			s_nxt.arready = 1'b1;
		if (s_r.rvalid && i_rready)
			s_nxt.rvalid = 1'b0;
		if (s_r.arready && i_arvalid)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = trx_pkg::RESP_OKAY;
			case (ra)
			trx_pkg::REG_CMD:
				s_nxt.rdata = 32'(s_r.op) | (32'(s_r.maddr) << trx_pkg::CMD_MADDR_LSB)
					| (32'(s_r.imm) << trx_pkg::CMD_IMM_LSB);
			trx_pkg::REG_ACC:
				s_nxt.rdata = 32'(s_r.acc);
			trx_pkg::REG_TABLE_LOW_POINTER:
				s_nxt.rdata = 32'(s_r.table_low_pointer);
			trx_pkg::REG_TABLE_HIGH_POINTER:
				s_nxt.rdata = 32'(s_r.table_high_pointer) | (32'(s_r.table_high_pointer_en) << trx_pkg::TABLE_HIGH_POINTER_EN_BIT);
			trx_pkg::REG_PAGE:
				s_nxt.rdata = 32'(s_r.page);
			trx_pkg::REG_FLAGS:
				s_nxt.rdata = 32'(s_r.flags);
			trx_pkg::REG_TABLE_HIGH_LATCH:
				s_nxt.rdata = 32'(s_r.table_high_latch);
			trx_pkg::REG_STATUS:
				s_nxt.rdata = (32'(busy) << trx_pkg::STAT_BUSY_BIT)
					| (32'(s_r.reject) << trx_pkg::STAT_REJ_BIT);
			default:
			begin
				s_nxt.rdata = '0;
				s_nxt.rresp = trx_pkg::RESP_SLVERR;
			end
			endcase
		end

		////////////////////////////////////////////////////////////////////////////
		// Instruction sequence: REQ strobe, CAP data and xor, WB write back, FIN results shown
		case (s_r.state)
		trx_pkg::ST_IDLE:
		begin
			if (start)
			begin
				s_nxt.state = trx_pkg::ST_REQ;
				case (s_nxt.op)
				3'(trx_pkg::OP_TAB_PAGED):
				begin
					s_nxt.pm_rd = 1'b1;
					s_nxt.pm_addr = {(s_r.table_high_pointer_en ? s_r.table_high_pointer : s_r.page), s_r.table_low_pointer};
				end
				3'(trx_pkg::OP_TAB_LAST):
				begin
					s_nxt.pm_rd = 1'b1;
					s_nxt.pm_addr = {trx_pkg::LAST_PAGE, s_r.table_low_pointer};
				end
				3'(trx_pkg::OP_XOR_ACC), 3'(trx_pkg::OP_XOR_MEM):
				begin
					s_nxt.dm_rd = 1'b1;
					s_nxt.dm_addr = s_nxt.maddr;
				end
				default:
					s_nxt.dm_rd = 1'b0;
				endcase
			end
		end
		trx_pkg::ST_REQ:
			s_nxt.state = trx_pkg::ST_CAP;
		trx_pkg::ST_CAP:
		begin
			s_nxt.word = i_pm_data;
			xor_en = 1'b1;
			if (s_r.op == 3'(trx_pkg::OP_XOR_IMM))
				xor_b = s_r.imm;
			s_nxt.state = trx_pkg::ST_WB;
		end
		trx_pkg::ST_WB:
		begin
			s_nxt.state = trx_pkg::ST_FIN;
			s_nxt.dm_addr = s_r.maddr;
			// Flags other than zero are never touched here
			case (s_r.op)
			3'(trx_pkg::OP_TAB_PAGED), 3'(trx_pkg::OP_TAB_LAST):
			begin
				s_nxt.dm_wr = 1'b1;
				s_nxt.dm_wdata = s_r.word[trx_pkg::DATA_W-1:0];
				s_nxt.table_high_latch = s_r.word[trx_pkg::WORD_W-1:trx_pkg::DATA_W];
			end
			3'(trx_pkg::OP_XOR_ACC):
			begin
				s_nxt.acc = xor_res;
				s_nxt.flags[trx_pkg::FLAG_Z] = xor_zero;
			end
			3'(trx_pkg::OP_XOR_MEM):
			begin
				s_nxt.dm_wr = 1'b1;
				s_nxt.dm_wdata = xor_res;
				s_nxt.flags[trx_pkg::FLAG_Z] = xor_zero;
			end
			default:
			begin
				s_nxt.acc = xor_res;
				s_nxt.flags[trx_pkg::FLAG_Z] = xor_zero;
			end
			endcase
		end
		trx_pkg::ST_FIN:
			s_nxt.state = trx_pkg::ST_IDLE;
		default:
			s_nxt.state = trx_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			s_r <= trx_pkg::TOP_RST;
			busy_r <= 1'b0;
		end
		else
		begin
			s_r <= s_nxt;
			busy_r <= (s_nxt.state != trx_pkg::ST_IDLE);
		end
	end

	assign o_awready = s_r.awready;
	assign o_wready = s_r.wready;
	assign o_bvalid = s_r.bvalid;
	assign o_bresp = s_r.bresp;
	assign o_arready = s_r.arready;
	assign o_rvalid = s_r.rvalid;
	assign o_rdata = s_r.rdata;
	assign o_rresp = s_r.rresp;
	assign o_pm_rd = s_r.pm_rd;
	assign o_pm_addr = s_r.pm_addr;
	assign o_dm_rd = s_r.dm_rd;
	assign o_dm_wr = s_r.dm_wr;
	assign o_dm_addr = s_r.dm_addr;
	assign o_dm_wdata = s_r.dm_wdata;
	assign o_busy = busy_r;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	chk_paged_addr: assert property (
		o_pm_rd && s_r.op == 3'(trx_pkg::OP_TAB_PAGED) |->
		o_pm_addr == {($past(s_r.table_high_pointer_en) ? $past(s_r.table_high_pointer) : $past(s_r.page)), $past(s_r.table_low_pointer)})
		else $error("paged table read fetched the wrong address");

	chk_last_page: assert property (
		o_pm_rd && s_r.op == 3'(trx_pkg::OP_TAB_LAST) |->
		o_pm_addr == {trx_pkg::LAST_PAGE, s_r.table_low_pointer}
		##3 (o_dm_wr && o_dm_addr == s_r.maddr))
		else $error("last page table read address or write wrong");

	chk_table_latch: assert property (
		o_pm_rd |-> ##3 (o_dm_wr && o_dm_wdata == $past(i_pm_data[7:0], 2)
		&& s_r.table_high_latch == $past(i_pm_data[15:8], 2)))
		else $error("table word bytes not delivered together");

	chk_xor_acc: assert property (
		o_dm_rd && s_r.op == 3'(trx_pkg::OP_XOR_ACC) |->
		##3 (s_r.acc == ($past(s_r.acc, 3) ^ $past(i_dm_rdata, 2)) && !o_dm_wr))
		else $error("xor into accumulator wrong or memory written");

	chk_xor_mem: assert property (
		o_dm_rd && s_r.op == 3'(trx_pkg::OP_XOR_MEM) |->
		##3 (o_dm_wr && o_dm_wdata == ($past(s_r.acc, 3) ^ $past(i_dm_rdata, 2))
		&& s_r.flags[trx_pkg::FLAG_Z] == (o_dm_wdata == '0)))
		else $error("xor to memory result or zero flag wrong");

	chk_xor_imm: assert property (
		s_r.state == trx_pkg::ST_REQ && s_r.op == 3'(trx_pkg::OP_XOR_IMM) |->
		##3 (s_r.acc == ($past(s_r.acc, 3) ^ s_r.imm)
		&& s_r.flags[trx_pkg::FLAG_Z] == (s_r.acc == '0) && !o_dm_wr))
		else $error("immediate xor result or zero flag wrong");

	chk_flags_keep: assert property (
		s_r.state == trx_pkg::ST_FIN |->
		(s_r.flags & ~(6'h01 << trx_pkg::FLAG_Z)) == ($past(s_r.flags, 3)
		& ~(6'h01 << trx_pkg::FLAG_Z))
		&& (s_r.op > 3'(trx_pkg::OP_TAB_LAST) || s_r.flags == $past(s_r.flags, 3)))
		else $error("flags altered beyond the zero flag");

	cov_paged_high: cover property (o_pm_rd && s_r.op == 3'(trx_pkg::OP_TAB_PAGED)
		&& s_r.table_high_pointer_en);
	cov_last_page: cover property (o_pm_rd && s_r.op == 3'(trx_pkg::OP_TAB_LAST));
	cov_xor_zero: cover property (s_r.state == trx_pkg::ST_FIN && o_dm_wr
		&& s_r.flags[trx_pkg::FLAG_Z]);
endmodule
`default_nettype wire

//--- rtl/trx_pkg.sv
// Package with register map, opcodes, widths and state types of the table read and xor unit
`default_nettype none
package trx_pkg;
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	localparam int PM_AW = 12;
	localparam int PAGE_W = 4;
	localparam int PTR_W = 8;
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam int FLAG_W = 6;

	// Final program page of a 3K-word store
	localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hb;

	// Register byte offsets
	localparam logic [AXI_AW-1:0] REG_CMD = 8'h00;
	localparam logic [AXI_AW-1:0] REG_ACC = 8'h04;
	localparam logic [AXI_AW-1:0] REG_TABLE_LOW_POINTER = 8'h08;
	localparam logic [AXI_AW-1:0] REG_TABLE_HIGH_POINTER = 8'h0c;
	localparam logic [AXI_AW-1:0] REG_PAGE = 8'h10;
	localparam logic [AXI_AW-1:0] REG_FLAGS = 8'h14;
	localparam logic [AXI_AW-1:0] REG_TABLE_HIGH_LATCH = 8'h18;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h1c;

	// Field positions
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_MADDR_LSB = 8;
	localparam int CMD_IMM_LSB = 16;
	localparam int TABLE_HIGH_POINTER_EN_BIT = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_REJ_BIT = 1;
	localparam int FLAG_Z = 2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OP_TAB_PAGED,
		OP_TAB_LAST,
		OP_XOR_ACC,
		OP_XOR_MEM,
		OP_XOR_IMM
	} trx_op_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_REQ,
		ST_CAP,
		ST_WB,
		ST_FIN
	} trx_state_type;

	typedef struct packed {
		trx_state_type state;
		logic [2:0] op;
		logic [PTR_W-1:0] maddr;
		logic [DATA_W-1:0] imm;
		logic [DATA_W-1:0] acc;
		logic [PTR_W-1:0] table_low_pointer;
		logic [PAGE_W-1:0] table_high_pointer;
		logic table_high_pointer_en;
		logic [PAGE_W-1:0] page;
		logic [FLAG_W-1:0] flags;
		logic [DATA_W-1:0] table_high_latch;
		logic [WORD_W-1:0] word;
		logic reject;
		logic pm_rd;
		logic [PM_AW-1:0] pm_addr;
		logic dm_rd;
		logic dm_wr;
		logic [PTR_W-1:0] dm_addr;
		logic [DATA_W-1:0] dm_wdata;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [AXI_DW-1:0] rdata;
	} trx_top_state_type;

	typedef struct packed {
		logic [DATA_W-1:0] res;
		logic zero;
	} trx_xor_state_type;

	localparam trx_top_state_type TOP_RST = '0;
	localparam trx_xor_state_type XOR_RST = '0;
endpackage
`default_nettype wire

//--- rtl/trx_xor_unit.sv
// Registered exclusive-or of two bytes with zero detect
`default_nettype none
module trx_xor_unit
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Operands
	input wire logic i_en,
	input wire logic [trx_pkg::DATA_W-1:0] i_a,
	input wire logic [trx_pkg::DATA_W-1:0] i_b,
	// Result
	output logic [trx_pkg::DATA_W-1:0] o_res,
	output logic o_zero
);
	trx_pkg::trx_xor_state_type s_r;
	trx_pkg::trx_xor_state_type s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (i_en)
		begin
			s_nxt.res = i_a ^ i_b;
			s_nxt.zero = ((i_a ^ i_b) == '0);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			s_r <= trx_pkg::XOR_RST;
		else
			s_r <= s_nxt;
	end

	assign o_res = s_r.res;
	assign o_zero = s_r.zero;
endmodule
`default_nettype wire

//--- dv/trx_mem_model.sv
// Program and data memory model answering one cycle after each strobe
`default_nettype none
module trx_mem_model
(
	// Clock
	input wire logic i_clk,
	// Program memory
	input wire logic i_pm_rd,
	input wire logic [trx_pkg::PM_AW-1:0] i_pm_addr,
	output logic [trx_pkg::WORD_W-1:0] o_pm_data,
	output logic [trx_pkg::PM_AW-1:0] o_pm_seen,
	// Data memory
	input wire logic i_dm_rd,
	input wire logic i_dm_wr,
	input wire logic [7:0] i_dm_addr,
	input wire logic [7:0] i_dm_wdata,
	output logic [7:0] o_dm_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [256];
	initial
	begin
		o_pm_data = '0;
		o_pm_seen = '0;
		o_dm_rdata = '0;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	always @(posedge i_clk)
	begin
		// Data only valid one cycle; inverted after so stale values never match
		o_pm_data <= i_pm_rd ? {i_pm_addr[7:0] ^ 8'hc3, i_pm_addr[11:8], i_pm_addr[3:0]}
			: ~o_pm_data;
		o_dm_rdata <= i_dm_rd ? mem[i_dm_addr] : ~o_dm_rdata;
		if (i_pm_rd)
			o_pm_seen <= i_pm_addr;
		if (i_dm_wr)
			mem[i_dm_addr] <= i_dm_wdata;
	end
endmodule
`default_nettype wire

//--- dv/table_read_xor_execute_bench.sv
// Self-checking bench of the table read and xor unit
`default_nettype none
module table_read_xor_execute_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, pm_rd, dm_rd, dm_wr, busy;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [11:0] pm_addr, pm_seen;
	logic [15:0] pm_data;
	logic [7:0] dm_addr, dm_wdata, dm_rdata;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;

	always #5 i_clk = ~i_clk;

	trx_top DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_awvalid(awvalid), .o_awready(awready),
		.i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
		.i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
		.i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .o_pm_rd(pm_rd),
		.o_pm_addr(pm_addr), .i_pm_data(pm_data), .o_dm_rd(dm_rd), .o_dm_wr(dm_wr),
		.o_dm_addr(dm_addr), .o_dm_wdata(dm_wdata), .i_dm_rdata(dm_rdata), .o_busy(busy));

	trx_mem_model mem_model (.i_clk(i_clk), .i_pm_rd(pm_rd), .i_pm_addr(pm_addr),
		.o_pm_data(pm_data), .o_pm_seen(pm_seen), .i_dm_rd(dm_rd), .i_dm_wr(dm_wr),
		.i_dm_addr(dm_addr), .i_dm_wdata(dm_wdata), .o_dm_rdata(dm_rdata));

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Leading edge keeps a release and a new request out of one time step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge i_clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		forever
		begin
			@(posedge i_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] rexp);
		@(posedge i_clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		forever
		begin
			@(posedge i_clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				chk(name, rdata, exp);
				chk("rresp", {30'h0, rresp}, {30'h0, rexp});
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rexp);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk("bresp", {30'h0, r}, {30'h0, rexp});
	endtask

	task automatic exec(input logic [31:0] cmd);
		wr_ok(trx_pkg::REG_CMD, cmd, trx_pkg::RESP_OKAY);
		repeat (20)
		begin
			if (!busy)
				break;
			@(posedge i_clk);
		end
		chk("busy", {31'h0, busy}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_tab(input logic [2:0] op, input logic en);
		logic [11:0] pa;
		logic [15:0] w;
		pa = {(op == 3'h1) ? trx_pkg::LAST_PAGE : (en ? 4'h7 : 4'h3), 8'ha5};
		w = {pa[7:0] ^ 8'hc3, pa[11:8], pa[3:0]};
		wr_ok(trx_pkg::REG_TABLE_LOW_POINTER, 32'ha5, trx_pkg::RESP_OKAY);
		wr_ok(trx_pkg::REG_TABLE_HIGH_POINTER, {23'h0, en, 8'h07}, trx_pkg::RESP_OKAY);
		wr_ok(trx_pkg::REG_PAGE, 32'h3, trx_pkg::RESP_OKAY);
		wr_ok(trx_pkg::REG_FLAGS, 32'h2d, trx_pkg::RESP_OKAY);
		exec({16'h0, 8'h50, 5'h0, op});
		chk("pm_addr", {20'h0, pm_seen}, {20'h0, pa});
		chk("dm_low", {24'h0, mem_model.mem[8'h50]}, {24'h0, w[7:0]});
		rd_chk("latch", trx_pkg::REG_TABLE_HIGH_LATCH, {24'h0, w[15:8]}, trx_pkg::RESP_OKAY);
		rd_chk("flags", trx_pkg::REG_FLAGS, 32'h2d, trx_pkg::RESP_OKAY);
	endtask

	task automatic t_xor(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b);
		logic [7:0] res;
		logic [5:0] f;
		res = a ^ b;
		// Preset zero flag opposite to the expected one so an update shows
		f = (res == 8'h00) ? 6'h3b : 6'h3f;
		mem_model.mem[8'h40] = b;
		wr_ok(trx_pkg::REG_ACC, {24'h0, a}, trx_pkg::RESP_OKAY);
		wr_ok(trx_pkg::REG_FLAGS, {26'h0, f}, trx_pkg::RESP_OKAY);
		exec({8'h0, b, 8'h40, 5'h0, op});
		rd_chk("acc", trx_pkg::REG_ACC, {24'h0, (op == 3'h3) ? a : res},
			trx_pkg::RESP_OKAY);
		chk("mem", {24'h0, mem_model.mem[8'h40]}, {24'h0, (op == 3'h3) ? res : b});
		rd_chk("zflag", trx_pkg::REG_FLAGS, {26'h0, f ^ 6'h04},
			trx_pkg::RESP_OKAY);
	endtask

	task automatic t_refuse();
		rd_chk("unmapped", 8'h20, 32'h0, trx_pkg::RESP_SLVERR);
		wr_ok(trx_pkg::REG_TABLE_HIGH_LATCH, 32'h11, trx_pkg::RESP_SLVERR);
		wr_ok(trx_pkg::REG_CMD, 32'h7, trx_pkg::RESP_SLVERR);
		rd_chk("status", trx_pkg::REG_STATUS, 32'h2, trx_pkg::RESP_OKAY);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rd_chk("acc_rst", trx_pkg::REG_ACC, 32'h0, trx_pkg::RESP_OKAY);
		t_tab(3'h0, 1'b1);
		t_tab(3'h0, 1'b0);
		t_tab(3'h1, 1'b1);
		t_xor(3'h2, 8'h5c, 8'h3a);
		t_xor(3'h2, 8'h81, 8'h81);
		t_xor(3'h3, 8'hf0, 8'h0f);
		t_xor(3'h3, 8'h66, 8'h66);
		t_xor(3'h4, 8'h12, 8'h34);
		t_xor(3'h4, 8'ha7, 8'ha7);
		t_refuse();
		stop_test();
	end
endmodule
`default_nettype wire
